//--- rtl/dcsr_defs.svh
`ifndef DCSR_DEFS_SVH
`define DCSR_DEFS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define DCSR_OFF_CTRL     12'h004
`define DCSR_OFF_CTRL_SET 12'h008
`define DCSR_OFF_CTRL_CLR 12'h00C
`define DCSR_OFF_STAT     12'h040
`define DCSR_OFF_STAT_RC  12'h044
`define DCSR_OFF_TALLY    12'h048
`define DCSR_OFF_ALIGN    12'h04C
`define DCSR_OFF_WB_LO    12'h088
`define DCSR_OFF_WB_HI    12'h08C
`define DCSR_OFF_MASK     12'h090

// ----------------------------------------------------------------
// bit positions shared by control, status and mask words, and fields of the alignment word
// ----------------------------------------------------------------
`define DCSR_BIT_RUN      0
`define DCSR_BIT_HALT     1
`define DCSR_BIT_DONE     2
`define DCSR_BIT_ALIGN    3
`define DCSR_BIT_SIG      4
`define DCSR_BIT_LEN      5
`define DCSR_BIT_IDLE     6
`define DCSR_DESC_HI      23
`define DCSR_DESC_LO      19
`define DCSR_READ_HI      13
`define DCSR_READ_LO      9
`define DCSR_ALN_ADDR_HI  23
`define DCSR_ALN_ADDR_LO  16
`define DCSR_ALN_LEN_HI   15
`define DCSR_ALN_LEN_LO   8
`define DCSR_ALN_BITS_HI  7
`define DCSR_ALN_BITS_LO  0

// ----------------------------------------------------------------
// masks and reset values
// ----------------------------------------------------------------
`define DCSR_FAULT_ALL    5'h1F
`define DCSR_CTRL_WMASK   32'h0EF83E7F
`define DCSR_MASK_WMASK   32'h00F83E56
`define DCSR_RC_MASK      32'h00FFFFFE
`define DCSR_ZERO32       32'h00000000
`define DCSR_ONE32        32'h00000001
`define DCSR_ZERO5        5'h00
`define DCSR_READ_EV_MASK 5'h03
`define DCSR_DEF_ADDR_ALN 8'h40
`define DCSR_DEF_LEN_GRAN 8'h01
`define DCSR_DEF_ADDR_BIT 8'h40

`endif

//--- rtl/dcsr_pkg.sv
package dcsr_pkg;

  // whole register state of the channel status block
  typedef struct packed {
    logic [31:0] ctrl;
    logic [4:0]  desc_fault;
    logic [4:0]  read_fault;
    logic        halted_idle;
    logic        bad_length;
    logic        bad_sig;
    logic        misalign;
    logic        done_mark;
    logic        halt_mark;
    logic [31:0] tally;
    logic [31:0] wb_lo;
    logic [31:0] wb_hi;
    logic [31:0] mask;
    logic [31:0] prdata;
    logic        stop_pending;
    logic        stop_req;
    logic        irq;
  } dcsr_state_s;

  // per-descriptor events reported by the engine
  typedef struct packed {
    logic [4:0] desc_fault;
    logic [1:0] read_fault;
    logic       bad_length;
    logic       bad_sig;
    logic       misalign;
    logic       desc_done;
    logic       done_bit;
    logic       stop_bit;
  } dcsr_event_s;

endpackage

//--- rtl/dcsr_top.sv
`timescale 1ns/1ps
`include "dcsr_defs.svh"

module dcsr_top
  import dcsr_pkg::*;
#(
  parameter logic [7:0] P_ADDR_ALIGN = `DCSR_DEF_ADDR_ALN,
  parameter logic [7:0] P_LEN_GRAN   = `DCSR_DEF_LEN_GRAN,
  parameter logic [7:0] P_ADDR_BITS  = `DCSR_DEF_ADDR_BIT
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_engine_busy,
  input  wire dcsr_event_s i_event,
  output logic      [31:0] o_ctrl_word,
  output logic             o_run,
  output logic             o_engine_stop,
  output logic      [31:0] o_tally,
  output logic      [63:0] o_poll_wb_addr,
  output logic             o_irq
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_r;
  logic       rst_n;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] status_word(input dcsr_state_s s, input logic busy);
    logic [31:0] w;
    w = `DCSR_ZERO32;
    w[`DCSR_DESC_HI:`DCSR_DESC_LO] = s.desc_fault;
    w[`DCSR_READ_HI:`DCSR_READ_LO] = s.read_fault;
    w[`DCSR_BIT_IDLE]  = s.halted_idle;
    w[`DCSR_BIT_LEN]   = s.bad_length;
    w[`DCSR_BIT_SIG]   = s.bad_sig;
    w[`DCSR_BIT_ALIGN] = s.misalign;
    w[`DCSR_BIT_DONE]  = s.done_mark;
    w[`DCSR_BIT_HALT]  = s.halt_mark;
    w[`DCSR_BIT_RUN]   = busy;
    return w;
  endfunction

  function automatic logic addr_hit(input logic [11:0] a);
    logic h;
    h = 1'b0;
    case (a)
      `DCSR_OFF_CTRL, `DCSR_OFF_CTRL_SET, `DCSR_OFF_CTRL_CLR,
      `DCSR_OFF_STAT, `DCSR_OFF_STAT_RC, `DCSR_OFF_TALLY,
      `DCSR_OFF_ALIGN, `DCSR_OFF_WB_LO, `DCSR_OFF_WB_HI,
      `DCSR_OFF_MASK: h = 1'b1;
      default:        h = 1'b0;
    endcase
    return h;
  endfunction

  // ----------------------------------------------------------------
  // state update
  // ----------------------------------------------------------------
  dcsr_state_s st_r;
  dcsr_state_s st_nxt;
  logic        apb_setup;
  logic        apb_acc;
  logic        wr_acc;
  logic        rd_rc_acc;
  logic        run_rise;
  logic        run_fall;
  logic        desc_en;
  logic        read_en;
  logic [4:0]  desc_log;
  logic [4:0]  read_log;
  logic        sig_log;
  logic [31:0] cur_stat;
  logic [31:0] wmask;
  logic [31:0] clr_bits;

  assign apb_setup = i_psel & ~i_penable;
  assign apb_acc   = i_psel & i_penable;
  assign wr_acc    = apb_acc & i_pwrite;
  assign rd_rc_acc = apb_acc & ~i_pwrite & (i_paddr == `DCSR_OFF_STAT_RC);
  assign cur_stat  = status_word(st_r, i_engine_busy);

  always_comb begin
    st_nxt = st_r;
    st_nxt.stop_req = 1'b0;
    wmask = i_pwdata & `DCSR_CTRL_WMASK;

    // register writes: control word and its aliases, writeback address and mask
    if (wr_acc) begin
      case (i_paddr)
        `DCSR_OFF_CTRL:     st_nxt.ctrl = (st_r.ctrl & ~`DCSR_CTRL_WMASK) | wmask;
        `DCSR_OFF_CTRL_SET: st_nxt.ctrl = st_r.ctrl | wmask;
        `DCSR_OFF_CTRL_CLR: st_nxt.ctrl = st_r.ctrl & ~wmask;
        `DCSR_OFF_WB_LO:    st_nxt.wb_lo = i_pwdata;
        `DCSR_OFF_WB_HI:    st_nxt.wb_hi = i_pwdata;
        `DCSR_OFF_MASK:     st_nxt.mask = i_pwdata & `DCSR_MASK_WMASK;
        default:            st_nxt.ctrl = st_r.ctrl;
      endcase
    end
    run_rise = st_nxt.ctrl[`DCSR_BIT_RUN] & ~st_r.ctrl[`DCSR_BIT_RUN];
    run_fall = ~st_nxt.ctrl[`DCSR_BIT_RUN] & st_r.ctrl[`DCSR_BIT_RUN];

    // software clears come first so that a same-cycle event still lands
    clr_bits = `DCSR_ZERO32;
    if (wr_acc && (i_paddr == `DCSR_OFF_STAT)) begin
      clr_bits = i_pwdata & `DCSR_RC_MASK;
    end
    if (rd_rc_acc) begin
      clr_bits = st_r.prdata & `DCSR_RC_MASK;
    end
    st_nxt.desc_fault  = st_r.desc_fault & ~clr_bits[`DCSR_DESC_HI:`DCSR_DESC_LO];
    st_nxt.read_fault  = st_r.read_fault & ~clr_bits[`DCSR_READ_HI:`DCSR_READ_LO];
    st_nxt.halted_idle = st_r.halted_idle & ~clr_bits[`DCSR_BIT_IDLE];
    st_nxt.bad_length  = st_r.bad_length & ~clr_bits[`DCSR_BIT_LEN];
    st_nxt.bad_sig     = st_r.bad_sig & ~clr_bits[`DCSR_BIT_SIG];
    st_nxt.misalign    = st_r.misalign & ~clr_bits[`DCSR_BIT_ALIGN];
    st_nxt.done_mark   = st_r.done_mark & ~clr_bits[`DCSR_BIT_DONE];
    st_nxt.halt_mark   = st_r.halt_mark & ~clr_bits[`DCSR_BIT_HALT];

    // run set restarts the channel's bookkeeping
    if (run_rise) begin
      st_nxt.desc_fault   = `DCSR_ZERO5;
      st_nxt.read_fault   = `DCSR_ZERO5;
      st_nxt.halted_idle  = 1'b0;
      st_nxt.bad_length   = 1'b0;
      st_nxt.bad_sig      = 1'b0;
      st_nxt.done_mark    = 1'b0;
      st_nxt.halt_mark    = 1'b0;
      st_nxt.tally        = `DCSR_ZERO32;
      st_nxt.stop_pending = 1'b0;
    end

    // event logging, gated by current enables except misalignment and the tally
    desc_en  = (st_r.ctrl[`DCSR_DESC_HI:`DCSR_DESC_LO] == `DCSR_FAULT_ALL);
    read_en  = (st_r.ctrl[`DCSR_READ_HI:`DCSR_READ_LO] == `DCSR_FAULT_ALL);
    desc_log = desc_en ? i_event.desc_fault : `DCSR_ZERO5;
    read_log = read_en ? ({3'h0, i_event.read_fault} & `DCSR_READ_EV_MASK) : `DCSR_ZERO5;
    sig_log  = i_event.bad_sig & st_r.ctrl[`DCSR_BIT_SIG];
    st_nxt.desc_fault = st_nxt.desc_fault | desc_log;
    st_nxt.read_fault = st_nxt.read_fault | read_log;
    st_nxt.bad_length = st_nxt.bad_length
                      | (i_event.bad_length & st_r.ctrl[`DCSR_BIT_LEN]);
    st_nxt.bad_sig    = st_nxt.bad_sig | sig_log;
    st_nxt.misalign   = st_nxt.misalign | i_event.misalign;
    if (i_event.desc_done) begin
      st_nxt.done_mark = st_nxt.done_mark
                       | (i_event.done_bit & st_r.ctrl[`DCSR_BIT_DONE]);
      // stop-bit flag shares the signature enable, as the hardware does
      st_nxt.halt_mark = st_nxt.halt_mark
                       | (i_event.stop_bit & st_r.ctrl[`DCSR_BIT_SIG]);
      st_nxt.tally     = st_nxt.tally + `DCSR_ONE32;
    end
    // a logged fault or bad signature halts the engine
    st_nxt.stop_req = (|desc_log) | (|read_log) | sig_log;

    // halted-idle waits for the in-flight descriptor to drain
    if (run_fall) begin
      st_nxt.stop_pending = 1'b1;
    end else if (st_r.stop_pending && !i_engine_busy && !run_rise) begin
      st_nxt.stop_pending = 1'b0;
      st_nxt.halted_idle  = st_nxt.halted_idle | st_r.ctrl[`DCSR_BIT_IDLE];
    end

    // read data is captured in setup so the access phase needs no wait
    if (apb_setup && !i_pwrite) begin
      case (i_paddr)
        `DCSR_OFF_CTRL, `DCSR_OFF_CTRL_SET, `DCSR_OFF_CTRL_CLR:
                            st_nxt.prdata = st_r.ctrl;
        `DCSR_OFF_STAT:     st_nxt.prdata = cur_stat;
        `DCSR_OFF_STAT_RC:  st_nxt.prdata = cur_stat & `DCSR_RC_MASK;
        `DCSR_OFF_TALLY:    st_nxt.prdata = st_r.tally;
        `DCSR_OFF_ALIGN:    begin
          st_nxt.prdata = `DCSR_ZERO32;
          st_nxt.prdata[`DCSR_ALN_ADDR_HI:`DCSR_ALN_ADDR_LO] = P_ADDR_ALIGN;
          st_nxt.prdata[`DCSR_ALN_LEN_HI:`DCSR_ALN_LEN_LO]   = P_LEN_GRAN;
          st_nxt.prdata[`DCSR_ALN_BITS_HI:`DCSR_ALN_BITS_LO] = P_ADDR_BITS;
        end
        `DCSR_OFF_WB_LO:    st_nxt.prdata = st_r.wb_lo;
        `DCSR_OFF_WB_HI:    st_nxt.prdata = st_r.wb_hi;
        `DCSR_OFF_MASK:     st_nxt.prdata = st_r.mask;
        default:            st_nxt.prdata = `DCSR_ZERO32;
      endcase
    end

    // level request, held until software clears the flags
    st_nxt.irq = |(status_word(st_nxt, 1'b0) & st_nxt.mask);
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // zero wait states: read data is already registered at the setup edge
  assign o_pready       = 1'b1;
  assign o_pslverr      = apb_acc & ~addr_hit(i_paddr);
  assign o_prdata       = st_r.prdata;
  assign o_ctrl_word    = st_r.ctrl;
  assign o_run          = st_r.ctrl[`DCSR_BIT_RUN];
  assign o_engine_stop  = st_r.stop_req;
  assign o_tally        = st_r.tally;
  assign o_poll_wb_addr = {st_r.wb_hi, st_r.wb_lo};
  assign o_irq          = st_r.irq;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic any_event;
  assign any_event = (|i_event.desc_fault) | (|i_event.read_fault) | i_event.bad_length
                   | i_event.bad_sig | i_event.misalign | i_event.desc_done;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!rst_n);

  a_ctrl_set_alias: assert property (
    wr_acc && i_paddr == `DCSR_OFF_CTRL_SET
    |=> st_r.ctrl == ($past(st_r.ctrl) | ($past(i_pwdata) & `DCSR_CTRL_WMASK)))
    else $error("control set alias wrong");
  a_ctrl_clr_alias: assert property (
    wr_acc && i_paddr == `DCSR_OFF_CTRL_CLR
    |=> st_r.ctrl == ($past(st_r.ctrl) & ~($past(i_pwdata) & `DCSR_CTRL_WMASK)))
    else $error("control clear alias wrong");
  a_run_clears_flags: assert property (
    $rose(st_r.ctrl[`DCSR_BIT_RUN]) && !$past(any_event)
    |-> !st_r.bad_length && !st_r.bad_sig && !st_r.done_mark && !st_r.halt_mark
        && st_r.desc_fault == `DCSR_ZERO5 && st_r.tally == `DCSR_ZERO32)
    else $error("run set left flags or tally");
  a_busy_bit: assert property (
    apb_setup && !i_pwrite && i_paddr == `DCSR_OFF_STAT
    |=> o_prdata[`DCSR_BIT_RUN] == $past(i_engine_busy))
    else $error("busy bit mismatch");
  // a halted-idle flag raised during the read beats the clear, so leave it out
  a_rc_alias_clear: assert property (
    rd_rc_acc && !any_event && !$past(any_event) && !st_r.stop_pending
    |=> (status_word(st_r, 1'b0) & $past(st_r.prdata)) == `DCSR_ZERO32)
    else $error("read-clear alias kept bits");
  a_tally_count: assert property (
    i_event.desc_done && !run_rise |=> o_tally == $past(o_tally) + `DCSR_ONE32)
    else $error("tally did not count");
  a_sig_stops: assert property (
    i_event.bad_sig && st_r.ctrl[`DCSR_BIT_SIG] |=> o_engine_stop && st_r.bad_sig)
    else $error("bad signature not logged");
  a_fault_gate: assert property (
    desc_en == 1'b0 && !wr_acc && !rd_rc_acc && !run_rise
    |=> st_r.desc_fault == $past(st_r.desc_fault))
    else $error("fault logged while disabled");
  a_idle_flag: assert property (
    st_r.stop_pending && !i_engine_busy && st_r.ctrl[`DCSR_BIT_IDLE] && !run_fall && !run_rise
    |=> st_r.halted_idle)
    else $error("halted idle not set");
  a_irq_level: assert property (
    |(status_word(st_r, 1'b0) & st_r.mask) |-> o_irq)
    else $error("interrupt missing");
  // only software writes or the read-clear alias may drop a raised request
  a_irq_held: assert property (
    o_irq && !wr_acc && !rd_rc_acc |=> o_irq)
    else $error("interrupt dropped by itself");
  a_irq_needs_mask: assert property (
    o_irq |-> (status_word(st_r, 1'b0) & st_r.mask) != `DCSR_ZERO32)
    else $error("interrupt without a masked flag");
  a_wb_write: assert property (
    wr_acc && i_paddr == `DCSR_OFF_WB_HI |=> o_poll_wb_addr[63:32] == $past(i_pwdata))
    else $error("writeback high not written");

  // ----------------------------------------------------------------
  // assertions: event logging
  // ----------------------------------------------------------------
  // set beats clear, so these hold even under a same-cycle clear or run set
  a_len_logged: assert property (
    i_event.bad_length && st_r.ctrl[`DCSR_BIT_LEN] |=> st_r.bad_length)
    else $error("bad length not logged");
  a_misalign_set: assert property (
    i_event.misalign |=> st_r.misalign)
    else $error("misalignment not logged");
  a_done_logged: assert property (
    i_event.desc_done && i_event.done_bit && st_r.ctrl[`DCSR_BIT_DONE] |=> st_r.done_mark)
    else $error("done marker not logged");
  a_halt_logged: assert property (
    i_event.desc_done && i_event.stop_bit && st_r.ctrl[`DCSR_BIT_SIG] |=> st_r.halt_mark)
    else $error("halt marker not logged");
  a_desc_fault_stop: assert property (
    desc_en && (|i_event.desc_fault)
    |=> o_engine_stop
        && (st_r.desc_fault & $past(i_event.desc_fault)) == $past(i_event.desc_fault))
    else $error("descriptor fault not logged or engine not stopped");
  a_read_fault_stop: assert property (
    read_en && (|i_event.read_fault) |=> o_engine_stop)
    else $error("read fault did not stop engine");
  // bad length and misalignment are logged only, they never halt the engine
  a_stop_quiet: assert property (
    !i_event.bad_sig && !(|i_event.desc_fault) && !(|i_event.read_fault) |=> !o_engine_stop)
    else $error("stop without a fault");
  // only slave and decode errors exist in the read fault field
  a_read_rsvd: assert property (
    (st_r.read_fault & ~`DCSR_READ_EV_MASK) == `DCSR_ZERO5)
    else $error("reserved read fault bit set");
  a_sig_gate: assert property (
    !st_r.ctrl[`DCSR_BIT_SIG] && !wr_acc && !rd_rc_acc |=> st_r.bad_sig == $past(st_r.bad_sig))
    else $error("bad signature logged while disabled");
  a_len_gate: assert property (
    !st_r.ctrl[`DCSR_BIT_LEN] && !wr_acc && !rd_rc_acc
    |=> st_r.bad_length == $past(st_r.bad_length))
    else $error("bad length logged while disabled");

  // ----------------------------------------------------------------
  // assertions: register contents
  // ----------------------------------------------------------------
  // reserved bits must read back zero whatever software writes
  a_ctrl_rsvd: assert property (
    (o_ctrl_word & ~`DCSR_CTRL_WMASK) == `DCSR_ZERO32)
    else $error("reserved control bit set");
  a_mask_rsvd: assert property (
    (st_r.mask & ~`DCSR_MASK_WMASK) == `DCSR_ZERO32)
    else $error("reserved mask bit set");
  // a write to the tally must not move it; only finished descriptors and a run set may
  a_tally_readonly: assert property (
    wr_acc && i_paddr == `DCSR_OFF_TALLY && !i_event.desc_done |=> o_tally == $past(o_tally))
    else $error("tally written by software");
  a_run_zero_tally: assert property (
    run_rise && !i_event.desc_done |=> o_tally == `DCSR_ZERO32)
    else $error("tally not zeroed on run");
  a_wb_low_write: assert property (
    wr_acc && i_paddr == `DCSR_OFF_WB_LO |=> o_poll_wb_addr[31:0] == $past(i_pwdata))
    else $error("writeback low not written");
  a_run_clear: assert property (
    wr_acc && i_paddr == `DCSR_OFF_CTRL_CLR && i_pwdata[`DCSR_BIT_RUN] |=> !o_run)
    else $error("run not cleared");

endmodule

//--- verif/dcsr_top_tb.sv
`timescale 1ns/1ps

module dcsr_top_tb;
  import dcsr_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        busy;
  dcsr_event_s ev;
  logic [31:0] ctrl_word;
  logic        run;
  logic        eng_stop;
  logic [31:0] tally;
  logic [63:0] wb_addr;
  logic        irq;
  logic        last_err;
  logic [31:0] dummy;
  int          fail_count;
  int          samples_checked;

  dcsr_top #(
    .P_ADDR_ALIGN (8'h20),
    .P_LEN_GRAN   (8'h04),
    .P_ADDR_BITS  (8'h30)
  ) u_dcsr_top (
    .i_core_clk     (clk),
    .i_rst_n        (rst_n),
    .i_psel         (psel),
    .i_penable      (penable),
    .i_pwrite       (pwrite),
    .i_paddr        (paddr),
    .i_pwdata       (pwdata),
    .o_prdata       (prdata),
    .o_pready       (pready),
    .o_pslverr      (pslverr),
    .i_engine_busy  (busy),
    .i_event        (ev),
    .o_ctrl_word    (ctrl_word),
    .o_run          (run),
    .o_engine_stop  (eng_stop),
    .o_tally        (tally),
    .o_poll_wb_addr (wb_addr),
    .o_irq          (irq)
  );

  always #2.5 clk = ~clk;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // holds the request until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // a slave that never answers is ended by the watchdog
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd       = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, dummy);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    apb(1'b0, a, 32'h00000000, d);
    chk(d, exp);
  endtask

  // one-cycle engine event; the stop pulse is looked at mid-cycle while it stands
  task automatic pulse(input logic [12:0] v, input logic stop_exp);
    ev <= dcsr_event_s'(v);
    @(posedge clk);
    ev <= dcsr_event_s'(13'h0000);
    @(negedge clk);
    chk(eng_stop, stop_exp);
    @(posedge clk);
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h00000000; busy = 1'b0;
    ev = dcsr_event_s'(13'h0000); fail_count = 0; samples_checked = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rdc(12'h088, 32'h00000000);
    rdc(12'h08C, 32'h00000000);
    rdc(12'h048, 32'h00000000);
    rdc(12'h040, 32'h00000000);
    rdc(12'h04C, 32'h00200430);
    // enables all off: nothing may be logged or stop the engine
    pulse(13'h1F20, 1'b0);
    rdc(12'h040, 32'h00000000);
    wr(12'h008, 32'h00F83E7E);
    rdc(12'h004, 32'h00F83E7E);
    chk(ctrl_word, 32'h00F83E7E);
    wr(12'h00C, 32'h00080000);
    rdc(12'h004, 32'h00F03E7E);
    pulse(13'h1F00, 1'b0);
    rdc(12'h040, 32'h00000000);
    wr(12'h008, 32'h00080000);
    rdc(12'h004, 32'h00F83E7E);
    pulse(13'h1500, 1'b1);
    rdc(12'h040, 32'h00A80000);
    wr(12'h040, 32'h00080000);
    rdc(12'h040, 32'h00A00000);
    pulse(13'h00C0, 1'b1);
    pulse(13'h0020, 1'b0);
    pulse(13'h0010, 1'b1);
    pulse(13'h0008, 1'b0);
    pulse(13'h0006, 1'b0);
    pulse(13'h0005, 1'b0);
    chk(tally, 32'h00000002);
    rdc(12'h040, 32'h00A0063E);
    wr(12'h048, 32'hFFFFFFFF);
    rdc(12'h048, 32'h00000002);
    chk(irq, 1'b0);
    wr(12'h090, 32'h00000010);
    chk(irq, 1'b1);
    wr(12'h090, 32'hFFFFFFFF);
    rdc(12'h090, 32'h00F83E56);
    busy <= 1'b1;
    repeat (2) @(posedge clk);
    rdc(12'h040, 32'h00A0063F);
    busy <= 1'b0;
    repeat (2) @(posedge clk);
    rdc(12'h044, 32'h00A0063E);
    rdc(12'h040, 32'h00000000);
    chk(irq, 1'b0);
    // flags and tally wiped by a run rising edge
    busy <= 1'b1;
    pulse(13'h0027, 1'b0);
    rdc(12'h040, 32'h00000027);
    wr(12'h008, 32'h00000001);
    chk(run, 1'b1);
    rdc(12'h040, 32'h00000001);
    rdc(12'h048, 32'h00000000);
    wr(12'h00C, 32'h00000001);
    chk(run, 1'b0);
    rdc(12'h040, 32'h00000001);
    busy <= 1'b0;
    repeat (3) @(posedge clk);
    rdc(12'h040, 32'h00000040);
    chk(irq, 1'b1);
    wr(12'h088, 32'h89ABCDEF);
    wr(12'h08C, 32'h01234567);
    rdc(12'h088, 32'h89ABCDEF);
    chk(last_err, 1'b0);
    rdc(12'h08C, 32'h01234567);
    chk(wb_addr[31:0], 32'h89ABCDEF);
    chk(wb_addr[63:32], 32'h01234567);
    // primary word: reserved bits stay zero, run is left clear
    wr(12'h004, 32'hFFFFFFFE);
    rdc(12'h004, 32'h0EF83E7E);
    chk(run, 1'b0);
    // event in the same cycle as its write-one-to-clear: the set wins
    fork
      wr(12'h040, 32'h00000020);
      begin
        @(posedge clk);
        ev <= dcsr_event_s'(13'h0020);
        @(posedge clk);
        ev <= dcsr_event_s'(13'h0000);
      end
    join
    rdc(12'h040, 32'h00000060);
    // unmapped place answers with an error and zero data
    rdc(12'h094, 32'h00000000);
    chk(last_err, 1'b1);
    print_verdict();
  end

  // run needs well under a thousand cycles
  initial begin
    #20000;
    fail_count++;
    $display("FAIL %0t watchdog expired", $time);
    print_verdict();
  end

endmodule
